/* File: common/sehto_defs.svh */
/*
   Constants of the enable handshake supervisor: register offsets, field
   positions, reset values and bus response codes.
   Assumes it is included by bare name from the top-level design file only; the package does not include it.
*/
// Contract
// - Release timeout field used in master mode only.
// - Release window counts bit periods after select inactive.
// - Enable still active at expiry sets slave_flag_a.
// - Enable released during transfer sets slave_flag_a.
// - Both timeouts tick on format bit clock.
// - Response timeout needs master and handshake mode.
// - Response window counts from select activation.
// - No enable at response expiry sets timeout.
// - Select timing never waits on slave enable.
`ifndef SEHTO_DEFS_SVH
`define SEHTO_DEFS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets.
// -----------------------------------------------------------------------------
`define SEHTO_OFF_DELAY    8'h00
`define SEHTO_OFF_CTRL     8'h04
`define SEHTO_OFF_FLAG     8'h08
`define SEHTO_OFF_MASK     8'h0c
`define SEHTO_OFF_STATE    8'h10

// -----------------------------------------------------------------------------
// Field positions and widths.
// -----------------------------------------------------------------------------
`define SEHTO_LIM_W        8
`define SEHTO_RESP_LSB     0
`define SEHTO_REL_LSB      8
`define SEHTO_CTRL_MASTER  0
`define SEHTO_CTRL_HS      1
`define SEHTO_CTRL_PRE_LSB 8
`define SEHTO_CTRL_MASK    32'h0000ff03
`define SEHTO_FLAG_TMO     0
`define SEHTO_FLAG_DSY     1
`define SEHTO_STATE_LSB    4

// -----------------------------------------------------------------------------
// Reset values and bus responses.
// -----------------------------------------------------------------------------
`define SEHTO_DELAY_RST    32'h00000000
`define SEHTO_CTRL_RST     32'h00000000
`define SEHTO_FLAG_RST     2'h0
`define SEHTO_MASK_RST     2'h0
`define SEHTO_RESP_OKAY    2'h0
`define SEHTO_RESP_SLVERR  2'h2

`endif

/* File: common/sehto_pkg.sv */
/*
   Types of the enable handshake supervisor.
   Assumes the constants header is on the include path.
*/
`default_nettype none
package sehto_pkg;
   // Supervision states, one-hot.
   typedef enum logic [3:0] {
      sehto_idle = 4'h1,
      sehto_resp = 4'h2,
      sehto_hold = 4'h4,
      sehto_rel  = 4'h8
   } sehto_state_type;
endpackage
`default_nettype wire

/* File: hw/sehto_sync.sv */
/*
   Two-flop synchroniser for one level.
   Assumes the input is asynchronous to clk and only the output is read.
*/
`default_nettype none
module sehto_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;  // First stage, read only by the second stage.

   // -----------------------------------------------------------------------
   // Two stages; the reset value keeps the level at its idle sense.
   // -----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         dout   <= RST_VAL;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* File: hw/sehto_timer.sv */
/*
   Timeout counter measured in bit-clock periods of prescale+1 clocks.
   Assumes run and clr come from logic on the same clock.
*/
`default_nettype none
module sehto_timer (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       clr,
   input  wire logic [7:0] prescale,
   input  wire logic [7:0] limit,
   output logic            expire
);
   logic [7:0] pre_q;    // Clocks within the current bit period.
   logic [8:0] cnt_q;    // Whole bit periods elapsed.
   logic       tick;     // Last clock of a bit period.
   logic [8:0] cnt_inc;  // Period count including this one.

   assign tick    = (pre_q == prescale);
   assign cnt_inc = cnt_q + 9'h001;
   // A limit of zero or one both expire at the end of the first period.
   assign expire  = run & tick & (cnt_inc >= {1'b0, limit});

   // -----------------------------------------------------------------------
   // Counting; an idle or cleared timer restarts from zero.
   // -----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || clr || !run) begin
         pre_q <= 8'h00;
         cnt_q <= 9'h000;
      end else begin
         pre_q <= tick ? 8'h00 : pre_q + 8'h01;
         if (tick && !expire) begin
            cnt_q <= cnt_inc;
         end
      end
   end

   period_two_a: assert property (@(posedge clk) disable iff (!rst_n)
      (run && !clr && pre_q == 8'h00 && prescale == 8'h01) ##1 (run && !clr && prescale == 8'h01) |-> tick)
      else $error("bit period is not prescale plus one clocks");
endmodule
`default_nettype wire

/* File: hw/sehto_top.sv */
/*
   Enable handshake supervisor of an SPI master with an AXI4-Lite register
   slave, sticky flags, an interrupt mask and one level interrupt.
   Assumes cs_active and xfer_active come from the transfer engine on aclk,
   and the slave enable pin is asynchronous and active low.
*/
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`include "sehto_defs.svh"
`default_nettype none
module sehto_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        slave_enable_handshake_n,
   input  wire logic        cs_active,
   input  wire logic        xfer_active,
   output logic             irq
);
   // -----------------------------------------------------------------------
   // Declarations.
   // -----------------------------------------------------------------------
   logic [7:0]  aw_addr_q;     // Held write address.
   logic [31:0] w_data_q;      // Held write data.
   logic [3:0]  w_strb_q;      // Held write strobes.
   logic [31:0] delay_q;       // Both handshake limits.
   logic [31:0] delay_d;       // Next limits after a write.
   logic [31:0] ctrl_q;        // Mode bits and prescale.
   logic [31:0] ctrl_d;        // Next control after a write.
   logic [1:0]  flag_q;        // Sticky timeout and slave_flag_a flags.
   logic [1:0]  flag_d;        // Next flags.
   logic [1:0]  flag_set;      // Events of this cycle.
   logic [1:0]  flag_clr;      // Ones written to the flag register.
   logic [1:0]  mask_q;        // Interrupt mask.
   logic [31:0] wbyte_mask;    // Write strobes spread over bits.
   logic [7:0]  aw_word;       // Aligned write address.
   logic [7:0]  ar_word;       // Aligned read address.
   logic        do_wr;         // Address and data both held.
   logic        wr_delay;      // Write hits the limit register.
   logic        wr_ctrl;       // Write hits the control register.
   logic        wr_flag;       // Write hits the flag register.
   logic        wr_mask;       // Write hits the mask register.
   logic        wr_hit;        // Write address is mapped.
   logic        ar_take;       // Read address taken this cycle.
   logic        rd_hit;        // Read address is mapped.
   logic [31:0] rd_mux;        // Selected read word.
   logic [31:0] state_word;    // Live state as a read word.
   logic        ena_sync;      // Synchronised pin, active low.
   logic        ena_act;       // Slave enable asserted.
   logic        ena_act_q;     // Previous enable level.
   logic        ena_fall;      // Slave released enable.
   logic        cs_q;          // Previous select level.
   logic        cs_rise;       // Select went active.
   logic        cs_fall;       // Select went inactive.
   logic        ctrl_master;   // Master mode.
   logic        ctrl_hs;       // Slave uses the enable handshake.
   logic        early_rel;     // Enable dropped inside a transfer.
   logic        tmo_evt;       // Response timeout event.
   logic        dsy_evt;       // Release timeout event.
   logic        tmr_run;       // Timer supervises a window.
   logic        tmr_clr;       // State change restarts the timer.
   logic        tmr_expire;    // Window elapsed.
   logic [7:0]  tmr_limit;     // Limit of the current window.
   logic        irq_src;       // An unmasked flag is set.
   sehto_pkg::sehto_state_type state_q;  // Supervision state.
   sehto_pkg::sehto_state_type state_d;  // Next supervision state.

   // -----------------------------------------------------------------------
   // Pin synchroniser and edge detection.
   // -----------------------------------------------------------------------
   // The pin idles high, so the synchroniser resets high.
   sehto_sync #(
      .RST_VAL (1'b1)
   ) u_ena_sync (
      .clk   (aclk),
      .rst_n (aresetn),
      .din   (slave_enable_handshake_n),
      .dout  (ena_sync)
   );

   assign ena_act  = ~ena_sync;
   assign ena_fall = ena_act_q & ~ena_act;
   // Select edges are only observed; nothing here stalls select or clock.
   assign cs_rise  = cs_active & ~cs_q;
   assign cs_fall  = ~cs_active & cs_q;

   // Previous levels for edge detection.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ena_act_q <= 1'b0;
         cs_q      <= 1'b0;
      end else begin
         ena_act_q <= ena_act;
         cs_q      <= cs_active;
      end
   end

   // -----------------------------------------------------------------------
   // Mode decode.
   // -----------------------------------------------------------------------
   assign ctrl_master = ctrl_q[`SEHTO_CTRL_MASTER];
   assign ctrl_hs     = ctrl_q[`SEHTO_CTRL_HS];

   // -----------------------------------------------------------------------
   // Supervision state machine.
   // -----------------------------------------------------------------------
   // The response window only exists with the handshake in use; the
   // release window is kept in master mode whatever the handshake bit.
   always_comb begin
      state_d = state_q;
      tmo_evt = 1'b0;
      dsy_evt = 1'b0;
      case (state_q)
         sehto_pkg::sehto_idle: begin
            if (cs_rise && ctrl_master) begin
               // Window opens with the select edge.
               if (ctrl_hs && !ena_act) begin
                  state_d = sehto_pkg::sehto_resp;
               end else begin
                  state_d = sehto_pkg::sehto_hold;
               end
            end
         end
         sehto_pkg::sehto_resp: begin
            if (!ctrl_master || !ctrl_hs) begin
               state_d = sehto_pkg::sehto_idle;
            end else if (ena_act) begin
               // Slave answered in time.
               state_d = sehto_pkg::sehto_hold;
            end else if (tmr_expire) begin
               tmo_evt = 1'b1;
               state_d = sehto_pkg::sehto_hold;
            end else if (cs_fall) begin
               state_d = sehto_pkg::sehto_idle;
            end
         end
         sehto_pkg::sehto_hold: begin
            if (!ctrl_master) begin
               state_d = sehto_pkg::sehto_idle;
            end else if (cs_fall) begin
               // Only a still-asserted enable needs a release window.
               if (ena_act) begin
                  state_d = sehto_pkg::sehto_rel;
               end else begin
                  state_d = sehto_pkg::sehto_idle;
               end
            end
         end
         sehto_pkg::sehto_rel: begin
            if (!ctrl_master) begin
               state_d = sehto_pkg::sehto_idle;
            end else if (!ena_act) begin
               // Slave released in time.
               state_d = sehto_pkg::sehto_idle;
            end else if (tmr_expire) begin
               dsy_evt = 1'b1;
               state_d = sehto_pkg::sehto_idle;
            end else if (cs_rise) begin
               state_d = sehto_pkg::sehto_hold;
            end
         end
         default: begin
            state_d = sehto_pkg::sehto_idle;
         end
      endcase
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= sehto_pkg::sehto_idle;
      end else begin
         state_q <= state_d;
      end
   end

   // -----------------------------------------------------------------------
   // Shared timeout counter.
   // -----------------------------------------------------------------------
   // One counter serves both windows because they can never overlap.
   assign tmr_run   = (state_q == sehto_pkg::sehto_resp) | (state_q == sehto_pkg::sehto_rel);
   assign tmr_clr   = (state_d != state_q);
   assign tmr_limit = (state_q == sehto_pkg::sehto_rel) ? delay_q[`SEHTO_REL_LSB +: `SEHTO_LIM_W]
                                                         : delay_q[`SEHTO_RESP_LSB +: `SEHTO_LIM_W];

   // Bit periods follow the programmed prescale of the format.
   sehto_timer u_timer (
      .clk      (aclk),
      .rst_n    (aresetn),
      .run      (tmr_run),
      .clr      (tmr_clr),
      .prescale (ctrl_q[`SEHTO_CTRL_PRE_LSB +: `SEHTO_LIM_W]),
      .limit    (tmr_limit),
      .expire   (tmr_expire)
   );

   // -----------------------------------------------------------------------
   // Flags and interrupt.
   // -----------------------------------------------------------------------
   // A release seen while bits are still moving means lost clock edges.
   assign early_rel = ctrl_master & ctrl_hs & xfer_active & ena_fall;
   assign flag_set  = {dsy_evt | early_rel, tmo_evt};
   assign flag_clr  = (wr_flag && w_strb_q[0]) ? w_data_q[1:0] : 2'h0;
   // A new event wins over a clear in the same cycle.
   assign flag_d    = (flag_q & ~flag_clr) | flag_set;
   assign irq_src   = |(flag_q & mask_q);

   // Sticky flags and the registered interrupt level.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= `SEHTO_FLAG_RST;
         irq    <= 1'b0;
      end else begin
         flag_q <= flag_d;
         irq    <= irq_src;
      end
   end

   // -----------------------------------------------------------------------
   // Register write path.
   // -----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign wbyte_mask[gi*8 +: 8] = {8{w_strb_q[gi]}};
      end
   endgenerate

   assign aw_word  = {aw_addr_q[7:2], 2'b00};
   assign do_wr    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign wr_delay = do_wr & (aw_word == `SEHTO_OFF_DELAY);
   assign wr_ctrl  = do_wr & (aw_word == `SEHTO_OFF_CTRL);
   assign wr_flag  = do_wr & (aw_word == `SEHTO_OFF_FLAG);
   assign wr_mask  = do_wr & (aw_word == `SEHTO_OFF_MASK);
   // The state word is read only; writing it is accepted and ignored.
   assign wr_hit   = wr_delay | wr_ctrl | wr_flag | wr_mask | (aw_word == `SEHTO_OFF_STATE);
   assign delay_d  = (delay_q & ~wbyte_mask) | (w_data_q & wbyte_mask);
   assign ctrl_d   = ((ctrl_q & ~wbyte_mask) | (w_data_q & wbyte_mask)) & `SEHTO_CTRL_MASK;

   // Address and data are taken in either order and held until the response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SEHTO_RESP_OKAY;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            // Unmapped addresses answer with a slave error.
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SEHTO_RESP_OKAY : `SEHTO_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Software registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         delay_q <= `SEHTO_DELAY_RST;
         ctrl_q  <= `SEHTO_CTRL_RST;
         mask_q  <= `SEHTO_MASK_RST;
      end else begin
         if (wr_delay) begin
            delay_q <= delay_d;
         end
         if (wr_ctrl) begin
            ctrl_q <= ctrl_d;
         end
         if (wr_mask && w_strb_q[0]) begin
            mask_q <= w_data_q[1:0];
         end
      end
   end

   // -----------------------------------------------------------------------
   // Register read path.
   // -----------------------------------------------------------------------
   assign ar_word    = {s_axi_araddr[7:2], 2'b00};
   assign ar_take    = s_axi_arvalid & s_axi_arready;
   assign state_word = {24'h000000, state_q, 3'h0, ena_act};
   assign rd_hit     = (ar_word == `SEHTO_OFF_DELAY) | (ar_word == `SEHTO_OFF_CTRL) |
                       (ar_word == `SEHTO_OFF_FLAG) | (ar_word == `SEHTO_OFF_MASK) |
                       (ar_word == `SEHTO_OFF_STATE);
   assign rd_mux     = (ar_word == `SEHTO_OFF_DELAY) ? delay_q :
                       (ar_word == `SEHTO_OFF_CTRL)  ? ctrl_q :
                       (ar_word == `SEHTO_OFF_FLAG)  ? {30'h00000000, flag_q} :
                       (ar_word == `SEHTO_OFF_MASK)  ? {30'h00000000, mask_q} :
                       (ar_word == `SEHTO_OFF_STATE) ? state_word : 32'h00000000;

   // One read at a time; data are captured when the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `SEHTO_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? `SEHTO_RESP_OKAY : `SEHTO_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // -----------------------------------------------------------------------
   // Assertions and covers.
   // -----------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   resp_timeout_a: assert property (
      (state_q == sehto_pkg::sehto_resp) && tmr_expire && !ena_act && ctrl_master && ctrl_hs
      |=> flag_q[`SEHTO_FLAG_TMO] && (state_q == sehto_pkg::sehto_hold))
      else $error("response timeout did not raise the flag");
   rel_slave_flag_a_a: assert property (
      (state_q == sehto_pkg::sehto_rel) && tmr_expire && ena_act && ctrl_master
      |=> flag_q[`SEHTO_FLAG_DSY] && (state_q == sehto_pkg::sehto_idle))
      else $error("release timeout did not raise slave_flag_a");
   early_rel_a: assert property (
      ctrl_master && ctrl_hs && xfer_active && ena_fall |=> flag_q[`SEHTO_FLAG_DSY])
      else $error("early release did not raise slave_flag_a");
   resp_start_a: assert property (
      (state_q == sehto_pkg::sehto_idle) && cs_rise && ctrl_master && ctrl_hs && !ena_act
      |=> state_q == sehto_pkg::sehto_resp)
      else $error("select activation did not open the response window");
   resp_mode_a: assert property (
      (state_q == sehto_pkg::sehto_resp) |-> $past(ctrl_master) && $past(ctrl_hs))
      else $error("response window outside handshake master mode");
   rel_master_a: assert property (
      (state_q == sehto_pkg::sehto_rel) |-> $past(ctrl_master))
      else $error("release window outside master mode");
   rel_start_a: assert property (
      (state_q == sehto_pkg::sehto_hold) && cs_fall && ctrl_master && ena_act
      |=> state_q == sehto_pkg::sehto_rel)
      else $error("select release did not open the release window");
   rel_stop_a: assert property (
      (state_q == sehto_pkg::sehto_rel) && ctrl_master && !ena_act
      |=> (state_q == sehto_pkg::sehto_idle) && !flag_set[`SEHTO_FLAG_TMO])
      else $error("enable release did not stop the window");
   irq_level_a: assert property (
      ##1 (irq == $past(irq_src)))
      else $error("interrupt does not follow unmasked flags");
   set_wins_a: assert property (
      flag_set[`SEHTO_FLAG_DSY] && flag_clr[`SEHTO_FLAG_DSY] |=> flag_q[`SEHTO_FLAG_DSY])
      else $error("flag clear beat a new event");

   resp_timeout_c: cover property (tmo_evt);
   rel_slave_flag_a_c:   cover property (dsy_evt);
   early_rel_c:    cover property (early_rel);
   irq_rise_c:     cover property (!irq ##1 irq);
endmodule
`default_nettype wire

/* File: test/sehto_slave_model.sv */
/*
   Model of the external slave that drives the active-low enable pin.
   Assumes cs_active and xfer_active change just after aclk edges.
*/
`default_nettype none
module sehto_slave_model (
   input  wire logic aclk,
   input  wire logic cs_active,
   input  wire logic xfer_active,
   input  var  int   resp_dly,
   input  var  int   rel_dly,
   input  wire logic early,
   output logic      en_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int   cnt_q = 0;    // Cycles since the last select change.
   logic cs_q  = 1'b0; // Select level one cycle back.
   initial en_n = 1'b1;
   // Later assignments win, so an ordered early release beats the response.
   always @(posedge aclk) begin
      cnt_q <= (cs_active == cs_q) ? cnt_q + 1 : 0;
      cs_q  <= cs_active;
      if (cs_active && cnt_q >= resp_dly) en_n <= 1'b0;
      if (!cs_active && cnt_q >= rel_dly) en_n <= 1'b1;
      if (early && xfer_active) en_n <= 1'b1;
   end
endmodule
`default_nettype wire

/* File: test/spi_enable_handshake_timeouts_tb.sv */
/*
   Self-checking bench of the enable handshake supervisor.
   Assumes the design answers on AXI4-Lite and flags are sticky.
*/
`default_nettype none
module spi_enable_handshake_timeouts_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 1, arv = 0, rready = 1, cs = 0, xf = 0, early = 0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic [1:0]  rr, br;
   wire logic awready, wready, bvalid, arready, rvalid, irq, en_n;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   int n_mismatch = 0, tests_run = 0, cyc = 0, resp_dly = 1000, rel_dly = 0;
   sehto_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .slave_enable_handshake_n(en_n), .cs_active(cs), .xfer_active(xf), .irq(irq));
   sehto_slave_model slave (.aclk(aclk), .cs_active(cs), .xfer_active(xf), .resp_dly(resp_dly),
      .rel_dly(rel_dly), .early(early), .en_n(en_n));
   initial forever #50 aclk = ~aclk;
   // Cuts a hang short.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("mismatches %0d of %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ready lines stay high; each channel drops valid at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic a_ok, w_ok;
      a_ok = 0;
      w_ok = 0;
      awaddr <= a;
      wdata <= d;
      awv <= 1;
      wv <= 1;
      while (!(a_ok && w_ok)) begin
         @(posedge aclk);
         if (awready && !a_ok) awv <= 0;
         if (wready && !w_ok) wv <= 0;
         a_ok = a_ok | awready;
         w_ok = w_ok | wready;
      end
      do @(posedge aclk); while (!bvalid);
      br = bresp;
   endtask
   task automatic rdw(input logic [7:0] a);
      araddr <= a; arv <= 1;
      do @(posedge aclk); while (!arready);
      arv <= 0;
      while (!rvalid) @(posedge aclk);
      rd = rdata; rr = rresp;
   endtask
   task automatic t_regs();
      rdw(8'h00); chk("delay reset", 32'h0, rd);
      wr(8'h00, 32'h0000_0504); rdw(8'h00); chk("delay", 32'h0000_0504, rd);
      chk("write okay", 32'h0, {30'h0, br});
      wr(8'h40, 32'h0);
      chk("unmapped write", 32'h2, {30'h0, br});
      rdw(8'h40); chk("unmapped", 32'h2, {30'h0, rr});
      wr(8'h0c, 32'h3);
      $display("regs done");
   endtask
   task automatic t_resp_timeout(input logic [7:0] p);
      wr(8'h04, {16'h0, p, 8'h03}); resp_dly = 1000;
      cs <= 1; repeat ((p + 1) * 4 + 2) @(posedge aclk);
      chk("irq early", 32'h0, irq);
      @(posedge aclk); chk("irq", 32'h1, irq);
      rdw(8'h08); chk("flag", 32'h1, rd);
      cs <= 0; wr(8'h08, 32'h3);
      $display("timeout done");
   endtask
   task automatic t_release();
      wr(8'h04, 32'h3); resp_dly = 2; rel_dly = 1000;
      cs <= 1; repeat (20) @(posedge aclk); chk("irq answered", 32'h0, irq);
      rdw(8'h10);
      chk("state held", 32'h41, rd);
      cs <= 0; repeat (12) @(posedge aclk); chk("irq late", 32'h1, irq);
      rdw(8'h08); chk("slave_flag_a", 32'h2, rd);
      rel_dly = 0; wr(8'h08, 32'h3); rdw(8'h08); chk("cleared", 32'h0, rd);
      $display("release done");
   endtask
   task automatic t_early();
      cs <= 1; repeat (8) @(posedge aclk); xf <= 1; early <= 1;
      repeat (6) @(posedge aclk); rdw(8'h08); chk("early", 32'h2, rd);
      cs <= 0; xf <= 0; @(posedge aclk); early <= 0; wr(8'h08, 32'h3);
      // Handshake on but master off: neither window may open.
      wr(8'h04, 32'h2); resp_dly = 1000; cs <= 1; repeat (20) @(posedge aclk);
      chk("irq slave mode", 32'h0, irq);
      resp_dly = 0;
      rel_dly = 1000;
      repeat (4) @(posedge aclk);
      cs <= 0;
      repeat (20) @(posedge aclk);
      chk("irq no release window", 32'h0, irq);
      $display("early done");
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_regs();
      t_resp_timeout(8'h00);
      t_resp_timeout(8'h01);
      t_release();
      t_early();
      complete_run();
   end
endmodule
`default_nettype wire
